// >>> interrupt_entry_sequencer.sv
`timescale 1ns/1ns
// Notes on behaviour
// - interrupt request sampled only in fetch-start via interrupt-test condition
// - only fetch-start drives the interrupt-test condition code
// - fetch-start targets memory fetch; request raises bit to reach interrupt entry
// - entry copies full status word into memory data register
// - entry clears privilege bit, entering supervisor mode
// - entry writes priority into status bits 10..8, latches device vector
// - status word: privilege bit 15, priority 10..8, condition codes 2..0
// - after entry, old privilege zero goes to push-decrement, one to swap
// - swap saves stack pointer to user shadow, loads supervisor shadow
// - push-decrement decrements stack pointer and loads address register
// - push-write enables memory write until ready, then prepares counter push
// - data register gets program counter minus one
// - two more states decrement and write the saved counter
// - address register gets vector plus table base 0100
// - vector read holds until ready, start address in data register
// - final state loads program counter from data register
// - stack pointer loaded from matching shadow on privilege change
// - old stack pointer saved to matching shadow on privilege change
module interrupt_entry_sequencer
  import intseq_pkg::*;
(
  input wire logic mclk,
  input wire logic nrst,
  input wire logic intReq,
  input wire logic [2:0] intPriority,
  input wire logic [7:0] deviceVectorIn,
  input wire logic memReady,
  input wire logic [15:0] memReadData,
  output logic [5:0] stateCode,
  output logic [2:0] branchConditionSelect,
  output logic memoryIoEnable,
  output logic memWrite,
  output logic [15:0] memoryAddressReg,
  output logic [15:0] memoryDataReg,
  output logic [15:0] processorStatusWord,
  output logic [15:0] programCounter,
  output logic [15:0] stackPointerGpr,
  output logic [15:0] userSpShadow,
  output logic [15:0] supervisorSpShadow,
  output logic [7:0] vectorReg,
  output logic entryDone
);
  // -------------------------------------------------
  // state register and condition select
  // -------------------------------------------------
  state_type state_reg;
  branch_condition_select_type condSel;
  logic [5:0] jumpBase;
  logic [5:0] nextAddr;
  logic privSaved_reg;

  assign stateCode = state_reg;

  // -------------------------------------------------
  // condition select output, follows the state register
  // -------------------------------------------------
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      branchConditionSelect <= BRANCH_CONDITION_SELECT_INT;
    end else if (nextAddr == ST_FETCH_START) begin
      branchConditionSelect <= BRANCH_CONDITION_SELECT_INT;
    end else if (nextAddr == ST_INT_ENTRY) begin
      branchConditionSelect <= BRANCH_CONDITION_SELECT_PRIV;
    end else if (nextAddr == ST_PUSH_WRITE || nextAddr == ST_PC_WRITE
                 || nextAddr == ST_VEC_READ) begin
      branchConditionSelect <= BRANCH_CONDITION_SELECT_READY;
    end else begin
      branchConditionSelect <= BRANCH_CONDITION_SELECT_NONE;
    end
  end

  always_comb begin
    condSel = BRANCH_CONDITION_SELECT_NONE;
    jumpBase = state_reg;
    case (state_reg)
      ST_FETCH_START: begin
        condSel = BRANCH_CONDITION_SELECT_INT;
        jumpBase = ST_MEM_FETCH;
      end
      ST_MEM_FETCH: jumpBase = ST_FETCH_START;
      ST_INT_ENTRY: begin
        condSel = BRANCH_CONDITION_SELECT_PRIV;
        jumpBase = ST_PUSH_DEC;
      end
      ST_STACK_SWAP: jumpBase = ST_PUSH_DEC;
      ST_PUSH_DEC: jumpBase = ST_PUSH_WRITE;
      ST_PUSH_WRITE: begin
        condSel = BRANCH_CONDITION_SELECT_READY;
        jumpBase = ST_PUSH_WRITE;
      end
      ST_PC_PREP: jumpBase = ST_PC_DEC;
      ST_PC_DEC: jumpBase = ST_PC_WRITE;
      ST_PC_WRITE: begin
        condSel = BRANCH_CONDITION_SELECT_READY;
        jumpBase = ST_PC_WRITE;
      end
      ST_VEC_ADDR: jumpBase = ST_VEC_READ;
      ST_VEC_READ: begin
        condSel = BRANCH_CONDITION_SELECT_READY;
        jumpBase = ST_VEC_READ;
      end
      ST_LOAD_PC: jumpBase = ST_FETCH_START;
      default: jumpBase = ST_FETCH_START;
    endcase
  end

  next_state_mux nsMux (
    .condSel(condSel),
    .jumpBase(jumpBase),
    .intReq(intReq),
    .privBit(privSaved_reg),
    .memReady(memReady),
    .nextAddr(nextAddr)
  );

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= ST_FETCH_START;
    end else begin
      state_reg <= state_type'(nextAddr);
    end
  end

  // -------------------------------------------------
  // memory strobes
  // -------------------------------------------------
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      memoryIoEnable <= 1'b0;
      memWrite <= 1'b0;
    end else begin
      memoryIoEnable <= (nextAddr == ST_PUSH_WRITE) || (nextAddr == ST_PC_WRITE)
                        || (nextAddr == ST_VEC_READ) || (nextAddr == ST_MEM_FETCH);
      memWrite <= (nextAddr == ST_PUSH_WRITE) || (nextAddr == ST_PC_WRITE);
    end
  end

  // -------------------------------------------------
  // status word, vector, privilege
  // -------------------------------------------------
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      processorStatusWord <= PSR_RESET;
      vectorReg <= BYTE_ZERO;
      privSaved_reg <= 1'b0;
    end else if (state_reg == ST_FETCH_START && nextAddr == ST_INT_ENTRY) begin
      privSaved_reg <= processorStatusWord[PRIV_BIT];
    end else if (state_reg == ST_INT_ENTRY) begin
      processorStatusWord[PRIV_BIT] <= 1'b0;
      processorStatusWord[PRIO_HI:PRIO_LO] <= intPriority;
      vectorReg <= deviceVectorIn;
    end
  end

  // -------------------------------------------------
  // stack pointer and shadows
  // -------------------------------------------------
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      stackPointerGpr <= WORD_ZERO;
      userSpShadow <= WORD_ZERO;
      supervisorSpShadow <= WORD_ZERO;
    end else if (state_reg == ST_STACK_SWAP) begin
      userSpShadow <= stackPointerGpr;
      stackPointerGpr <= supervisorSpShadow;
    end else if (state_reg == ST_PUSH_DEC || state_reg == ST_PC_DEC) begin
      stackPointerGpr <= stackPointerGpr - WORD_ONE;
    end
  end

  // -------------------------------------------------
  // address, data and program counter
  // -------------------------------------------------
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      memoryAddressReg <= WORD_ZERO;
      memoryDataReg <= WORD_ZERO;
      programCounter <= WORD_ZERO;
      entryDone <= 1'b0;
    end else begin
      entryDone <= 1'b0;
      case (state_reg)
        ST_FETCH_START: begin
          memoryAddressReg <= programCounter;
          programCounter <= programCounter + WORD_ONE;
        end
        ST_INT_ENTRY: memoryDataReg <= processorStatusWord;
        ST_PUSH_DEC, ST_PC_DEC: memoryAddressReg <= stackPointerGpr - WORD_ONE;
        ST_PC_PREP: memoryDataReg <= programCounter - WORD_ONE;
        ST_VEC_ADDR: memoryAddressReg <= VECTOR_BASE + {8'h00, vectorReg};
        ST_VEC_READ: if (memReady) memoryDataReg <= memReadData;
        ST_LOAD_PC: begin
          programCounter <= memoryDataReg;
          entryDone <= 1'b1;
        end
        default: memoryDataReg <= memoryDataReg;
      endcase
    end
  end

  // -------------------------------------------------
  // checks
  // -------------------------------------------------
  sequence s_pushWait;
    (state_reg == ST_PUSH_WRITE) && !memReady;
  endsequence

  sequence s_pcWait;
    (state_reg == ST_PC_WRITE) && !memReady;
  endsequence

  sequence s_vecWait;
    (state_reg == ST_VEC_READ) && !memReady;
  endsequence

  sequence s_entryStart;
    (state_reg == ST_FETCH_START) && intReq;
  endsequence

  sequence s_entryPath;
    (state_reg == ST_INT_ENTRY) ##1 (state_reg == ST_PUSH_DEC || state_reg == ST_STACK_SWAP);
  endsequence

  sequence s_pcPush;
    (state_reg == ST_PC_PREP) ##1 (state_reg == ST_PC_DEC) ##1 (state_reg == ST_PC_WRITE);
  endsequence

  a_int_only_fetch: assert property (@(posedge mclk) disable iff (!nrst)
    condSel == BRANCH_CONDITION_SELECT_INT |-> state_reg == ST_FETCH_START)
    else $error("interrupt test outside fetch-start");

  a_int_entry_taken: assert property (@(posedge mclk) disable iff (!nrst)
    state_reg == ST_FETCH_START && intReq |=> state_reg == ST_INT_ENTRY)
    else $error("request not taken");

  a_entry_path: assert property (@(posedge mclk) disable iff (!nrst)
    s_entryStart |=> s_entryPath)
    else $error("entry path wrong");

  a_no_int_fetch: assert property (@(posedge mclk) disable iff (!nrst)
    state_reg == ST_FETCH_START && !intReq |=> state_reg == ST_MEM_FETCH)
    else $error("fetch not entered");

  a_branch_condition_select_fetch_out: assert property (@(posedge mclk) disable iff (!nrst)
    state_reg == ST_FETCH_START |-> branchConditionSelect == BRANCH_CONDITION_SELECT_INT)
    else $error("fetch-start select wrong");

  a_branch_condition_select_other_out: assert property (@(posedge mclk) disable iff (!nrst)
    state_reg != ST_FETCH_START |-> branchConditionSelect != BRANCH_CONDITION_SELECT_INT)
    else $error("interrupt select outside fetch-start");

  a_entry_psr: assert property (@(posedge mclk) disable iff (!nrst)
    state_reg == ST_INT_ENTRY |=> !processorStatusWord[PRIV_BIT]
      && processorStatusWord[PRIO_HI:PRIO_LO] == $past(intPriority)
      && memoryDataReg == $past(processorStatusWord))
    else $error("entry status update wrong");

  a_entry_vector: assert property (@(posedge mclk) disable iff (!nrst)
    state_reg == ST_INT_ENTRY |=> vectorReg == $past(deviceVectorIn))
    else $error("vector not latched");

  a_priv_branch: assert property (@(posedge mclk) disable iff (!nrst)
    state_reg == ST_INT_ENTRY |=> state_reg == (privSaved_reg ? ST_STACK_SWAP : ST_PUSH_DEC))
    else $error("privilege branch wrong");

  a_swap_sp: assert property (@(posedge mclk) disable iff (!nrst)
    state_reg == ST_STACK_SWAP |=> stackPointerGpr == $past(supervisorSpShadow)
      && userSpShadow == $past(stackPointerGpr) && state_reg == ST_PUSH_DEC)
    else $error("stack swap wrong");

  a_push_dec: assert property (@(posedge mclk) disable iff (!nrst)
    state_reg == ST_PUSH_DEC |=> stackPointerGpr == $past(stackPointerGpr) - WORD_ONE
      && memoryAddressReg == stackPointerGpr)
    else $error("push decrement wrong");

  a_push_strobe: assert property (@(posedge mclk) disable iff (!nrst)
    state_reg == ST_PUSH_WRITE |-> memoryIoEnable && memWrite)
    else $error("push write strobe missing");

  a_push_wait: assert property (@(posedge mclk) disable iff (!nrst)
    s_pushWait |=> state_reg == ST_PUSH_WRITE)
    else $error("push write left early");

  a_pc_push_seq: assert property (@(posedge mclk) disable iff (!nrst)
    state_reg == ST_PUSH_WRITE && memReady |=> s_pcPush)
    else $error("pc push sequence wrong");

  a_pc_minus: assert property (@(posedge mclk) disable iff (!nrst)
    state_reg == ST_PC_PREP |=> memoryDataReg == $past(programCounter) - WORD_ONE)
    else $error("saved pc wrong");

  a_pc_strobe: assert property (@(posedge mclk) disable iff (!nrst)
    state_reg == ST_PC_WRITE |-> memoryIoEnable && memWrite)
    else $error("pc write strobe missing");

  a_pc_wait: assert property (@(posedge mclk) disable iff (!nrst)
    s_pcWait |=> state_reg == ST_PC_WRITE)
    else $error("pc write left early");

  a_vec_addr: assert property (@(posedge mclk) disable iff (!nrst)
    state_reg == ST_VEC_ADDR |=> memoryAddressReg == VECTOR_BASE + {8'h00, vectorReg})
    else $error("vector address wrong");

  a_read_strobe: assert property (@(posedge mclk) disable iff (!nrst)
    state_reg == ST_VEC_READ |-> memoryIoEnable && !memWrite)
    else $error("vector read strobe wrong");

  a_vec_wait: assert property (@(posedge mclk) disable iff (!nrst)
    s_vecWait |=> state_reg == ST_VEC_READ)
    else $error("vector read left early");

  a_vec_data: assert property (@(posedge mclk) disable iff (!nrst)
    state_reg == ST_VEC_READ && memReady |=> memoryDataReg == $past(memReadData)
      && state_reg == ST_LOAD_PC)
    else $error("start address not taken");

  a_load_pc: assert property (@(posedge mclk) disable iff (!nrst)
    state_reg == ST_LOAD_PC |=> programCounter == $past(memoryDataReg)
      && state_reg == ST_FETCH_START)
    else $error("pc load wrong");

  a_done_pulse: assert property (@(posedge mclk) disable iff (!nrst)
    state_reg == ST_LOAD_PC |=> entryDone ##1 !entryDone)
    else $error("entry done pulse wrong");
endmodule

// >>> interrupt_entry_sequencer_bench.sv
`timescale 1ns/1ns
module interrupt_entry_sequencer_bench
  import intseq_pkg::*;
();
  logic mclk = 1'b0, nrst = 1'b0, devPending = 1'b0;
  logic [2:0] devPriority = 3'h0, waitCycles = 3'h0, branchConditionSelect, intPriority;
  logic [7:0] devVector = 8'h00, deviceVectorIn, vectorReg;
  logic intReq, memReady, memoryIoEnable, memWrite, entryDone;
  logic [5:0] stateCode;
  logic [15:0] memReadData, memoryAddressReg, memoryDataReg, processorStatusWord;
  logic [15:0] programCounter, stackPointerGpr, userSpShadow, supervisorSpShadow;
  logic [15:0] expPsr = PSR_RESET, expSp = 16'h0000, expUsp = 16'h0000, pcAtEntry, isr;
  logic [15:0] expPc = 16'h0000;
  int num_errors = 0, compares = 0, cycles = 0, entries = 0;
  assign intPriority = devPriority;
  interrupt_entry_sequencer interrupt_entry_sequencer_inst (.mclk(mclk), .nrst(nrst),
    .intReq(intReq), .intPriority(intPriority), .deviceVectorIn(deviceVectorIn),
    .memReady(memReady), .memReadData(memReadData), .stateCode(stateCode),
    .branchConditionSelect(branchConditionSelect), .memoryIoEnable(memoryIoEnable),
    .memWrite(memWrite), .memoryAddressReg(memoryAddressReg), .memoryDataReg(memoryDataReg),
    .processorStatusWord(processorStatusWord), .programCounter(programCounter),
    .stackPointerGpr(stackPointerGpr), .userSpShadow(userSpShadow),
    .supervisorSpShadow(supervisorSpShadow), .vectorReg(vectorReg), .entryDone(entryDone));
  memory_irq_partner memory_irq_partner_inst (.mclk(mclk), .memoryIoEnable(memoryIoEnable),
    .memWrite(memWrite), .memoryAddressReg(memoryAddressReg), .memoryDataReg(memoryDataReg),
    .processorStatusWord(processorStatusWord), .waitCycles(waitCycles),
    .devPending(devPending), .devPriority(devPriority), .devVector(devVector),
    .memReady(memReady), .memReadData(memReadData), .intReq(intReq),
    .deviceVectorIn(deviceVectorIn));
  // ----------------------------------------
  // clock, timeout, helpers
  // ----------------------------------------
  always #25 mclk = ~mclk;
  always @(posedge mclk) begin
    cycles++;
    if (stateCode === ST_INT_ENTRY) entries++;
    if (nrst && stateCode === ST_FETCH_START) expPc++;
    if (stateCode === ST_LOAD_PC) expPc = isr;
    if (cycles == 20000) begin
      num_errors++;
      report_and_stop();
    end
  end
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task report_and_stop;
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  function automatic logic [15:0] entryPsr(input logic [15:0] old, input logic [2:0] p);
    entryPsr = old;
    entryPsr[PRIV_BIT] = 1'b0;
    entryPsr[PRIO_HI:PRIO_LO] = p;
  endfunction
  task automatic wait_state(input logic [5:0] s);
    int n = 0;
    while (stateCode !== s && n < 200) begin
      @(posedge mclk) #2;
      n++;
    end
  endtask
  // ----------------------------------------
  // one interrupt entry, checked end to end
  // ----------------------------------------
  task automatic one_irq(input logic [2:0] p, input logic [7:0] v, input logic [2:0] w);
    logic [15:0] oldPsr, spTop;
    @(posedge mclk) #2;
    isr = 16'($urandom);
    memory_irq_partner_inst.mem[VECTOR_BASE + 16'(v)] = isr;
    waitCycles = w;
    devPriority = p;
    devVector = v;
    devPending = 1'b1;
    wait_state(ST_INT_ENTRY);
    check("entry reached", 16'(stateCode), 16'(ST_INT_ENTRY));
    check("pc at entry", programCounter, expPc);
    check("branch_condition_select select", 16'(branchConditionSelect), 16'(BRANCH_CONDITION_SELECT_PRIV));
    pcAtEntry = expPc;
    oldPsr = expPsr;
    @(posedge mclk) #2;
    devPending = 1'b0;
    expPsr = entryPsr(oldPsr, p);
    check("saved status", memoryDataReg, oldPsr);
    check("status word", processorStatusWord, expPsr);
    check("vector reg", 16'(vectorReg), 16'(v));
    check("branch", 16'(stateCode), 16'(oldPsr[PRIV_BIT] ? ST_STACK_SWAP : ST_PUSH_DEC));
    if (oldPsr[PRIV_BIT]) begin
      expUsp = expSp;
      expSp = 16'h0000;
    end
    spTop = expSp;
    expSp = expSp - 16'h0002;
    wait_state(ST_LOAD_PC);
    @(posedge mclk) #2;
    check("service start", programCounter, isr);
    check("back to fetch", 16'(stateCode), 16'(ST_FETCH_START));
    check("entry done", 16'(entryDone), 16'h0001);
    check("start in data", memoryDataReg, isr);
    check("branch_condition_select select", 16'(branchConditionSelect), 16'(BRANCH_CONDITION_SELECT_INT));
    check("ssp shadow", supervisorSpShadow, 16'h0000);
    check("stack pointer", stackPointerGpr, expSp);
    check("user shadow", userSpShadow, expUsp);
    check("pushed status", memory_irq_partner_inst.mem[spTop - 16'h0001], oldPsr);
    check("pushed pc", memory_irq_partner_inst.mem[spTop - 16'h0002],
      pcAtEntry - 16'h0001);
  endtask
  initial begin
    void'($urandom(32'h0247));
    repeat (6) @(posedge mclk);
    #2 nrst = 1'b1;
    one_irq(3'h1, 8'hFF, 3'h0);
    one_irq(3'h2, 8'h00, 3'h3);
    for (int p = 3; p < 8; p++) begin
      one_irq(3'(p), 8'($urandom), 3'($urandom_range(3, 0)));
    end
    devPriority = 3'h5;
    devPending = 1'b1;
    repeat (40) @(posedge mclk);
    check("entry count", 16'(entries), 16'h0007);
    report_and_stop();
  end
endmodule

// >>> intseq_pkg.sv
package intseq_pkg;
  localparam int WORD_W = 16;
  // control-store style state codes (6-bit)
  typedef enum logic [5:0] {
    ST_FETCH_START = 6'h12,
    ST_MEM_FETCH   = 6'h21,
    ST_INT_ENTRY   = 6'h31,
    ST_PUSH_DEC    = 6'h25,
    ST_STACK_SWAP  = 6'h2D,
    ST_PUSH_WRITE  = 6'h29,
    ST_PC_PREP     = 6'h2B,
    ST_PC_DEC      = 6'h2F,
    ST_PC_WRITE    = 6'h30,
    ST_VEC_ADDR    = 6'h32,
    ST_VEC_READ    = 6'h34,
    ST_LOAD_PC     = 6'h36
  } state_type;
  typedef enum logic [2:0] {
    BRANCH_CONDITION_SELECT_NONE  = 3'h0,
    BRANCH_CONDITION_SELECT_READY = 3'h1,
    BRANCH_CONDITION_SELECT_PRIV  = 3'h4,
    BRANCH_CONDITION_SELECT_INT   = 3'h5
  } branch_condition_select_type;
  localparam logic [5:0] INT_JUMP_BIT = 6'h10;
  localparam logic [5:0] PRIV_JUMP_BIT = 6'h08;
  localparam logic [5:0] READY_JUMP_BIT = 6'h02;
  localparam int PRIV_BIT = 15;
  localparam int PRIO_HI = 10;
  localparam int PRIO_LO = 8;
  localparam logic [15:0] VECTOR_BASE = 16'h0100;
  localparam logic [15:0] PSR_RESET = 16'h8000;
  localparam logic [15:0] WORD_ZERO = 16'h0000;
  localparam logic [15:0] WORD_ONE = 16'h0001;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
endpackage

// >>> memory_irq_partner.sv
`timescale 1ns/1ns
// ----------------------------------------
// requester and slow memory
// ----------------------------------------
module memory_irq_partner
  import intseq_pkg::*;
(
  input wire logic mclk,
  input wire logic memoryIoEnable,
  input wire logic memWrite,
  input wire logic [15:0] memoryAddressReg,
  input wire logic [15:0] memoryDataReg,
  input wire logic [15:0] processorStatusWord,
  input wire logic [2:0] waitCycles,
  input wire logic devPending,
  input wire logic [2:0] devPriority,
  input wire logic [7:0] devVector,
  output logic memReady,
  output logic [15:0] memReadData,
  output logic intReq,
  output logic [7:0] deviceVectorIn
);
  logic [15:0] mem [0:65535];
  logic [2:0] waitCnt = 3'h0;
  logic [15:0] lastRd = 16'h0000;
  // request only above running priority
  assign intReq = devPending && (devPriority > processorStatusWord[PRIO_HI:PRIO_LO]);
  assign deviceVectorIn = intReq ? devVector : ~devVector;
  // ready only in the last cycle of an access
  assign memReady = memoryIoEnable && (waitCnt == waitCycles);
  assign memReadData = memReady ? mem[memoryAddressReg] : ~lastRd;
  always @(posedge mclk) begin
    waitCnt <= (memoryIoEnable && !memReady) ? waitCnt + 3'h1 : 3'h0;
    if (memReady && memWrite) mem[memoryAddressReg] <= memoryDataReg;
    if (memReady && !memWrite) lastRd <= memReadData;
  end
endmodule

// >>> next_state_mux.sv
`timescale 1ns/1ns
module next_state_mux
  import intseq_pkg::*;
(
  input wire branch_condition_select_type condSel,
  input wire logic [5:0] jumpBase,
  input wire logic intReq,
  input wire logic privBit,
  input wire logic memReady,
  output logic [5:0] nextAddr
);
  always_comb begin
    nextAddr = jumpBase;
    case (condSel)
      BRANCH_CONDITION_SELECT_INT: if (intReq) nextAddr = jumpBase | INT_JUMP_BIT;
      BRANCH_CONDITION_SELECT_PRIV: if (privBit) nextAddr = jumpBase | PRIV_JUMP_BIT;
      BRANCH_CONDITION_SELECT_READY: if (memReady) nextAddr = jumpBase | READY_JUMP_BIT;
      default: nextAddr = jumpBase;
    endcase
  end
endmodule
